// [verilog/spbc_params.svh]
`ifndef SPBC_PARAMS_SVH
`define SPBC_PARAMS_SVH

// sector count: 46 sectors addressed through A18..A11
`define SPBC_NUM_SECTORS 46
`define SPBC_SA_W 8
// command codes on the low data byte
`define SPBC_CMD_VLOCK_SET 8'h01
`define SPBC_CMD_VLOCK_CLR 8'h00
`define SPBC_CMD_NV_PE 8'h60
`define SPBC_CMD_RESET 8'hF0
// timing in nanoseconds and the clock period
`define SPBC_CLK_NS 20
`define SPBC_UNLOCK_GAP_NS 2000
`define SPBC_UNLOCK_BUSY_NS 1000
`define SPBC_NV_OP_NS 1000
`define SPBC_TIMEOUT_NS 4000
// least gap rounds up, busy time rounds down
`define SPBC_GAP_CYC \
   ((`SPBC_UNLOCK_GAP_NS + `SPBC_CLK_NS - 1) / `SPBC_CLK_NS)
`define SPBC_BUSY_CYC (`SPBC_UNLOCK_BUSY_NS / `SPBC_CLK_NS)
`define SPBC_NV_CYC (`SPBC_NV_OP_NS / `SPBC_CLK_NS)
`define SPBC_TMO_CYC (`SPBC_TIMEOUT_NS / `SPBC_CLK_NS)
`define SPBC_CNT_W 8
// status verify selectors
`define SPBC_VFY_VOL 2'h0
`define SPBC_VFY_PERS 2'h1
`define SPBC_VFY_FRZ 2'h2

`endif

// [verilog/spbc_pkg.sv]
package spbc_pkg;
   typedef enum logic [2:0] {
      SPBC_IDLE,
      SPBC_UNLOCK_BUSY,
      SPBC_NV_BUSY,
      SPBC_NV_TIMEOUT,
      SPBC_NV_DONE
   } spbc_state_t;
   typedef enum logic [1:0] {
      SPBC_OP_NONE,
      SPBC_OP_PROGRAM,
      SPBC_OP_ERASE
   } spbc_nvop_t;
endpackage

// [verilog/spbc_timer_if.sv]
interface spbc_timer_if;
   logic start;
   logic [7:0] load;
   logic done;
   modport ctl (output start, output load, input done);
   modport tmr (input start, input load, output done);
endinterface

// [verilog/spbc_timer.sv]
`include "spbc_params.svh"

module spbc_timer
(
   input wire logic sys_clk,
   input wire logic reset_n,
   spbc_timer_if.tmr tif
);
   logic [`SPBC_CNT_W-1:0] cnt_q;
   logic [`SPBC_CNT_W-1:0] cnt_d;
   logic run_q;
   logic run_d;
   logic done_q;

   assign cnt_d = tif.start ? tif.load :
                  (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
   assign run_d = tif.start | (run_q & (cnt_q != 8'h01));
   assign tif.done = done_q;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= 8'h00;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         // one-cycle pulse when a loaded count expires
         done_q <= run_q & ~tif.start & (cnt_q == 8'h01);
      end
   end
endmodule

// [verilog/spbc_core.sv]
`include "spbc_params.svh"

// Summary of operation
// - volatile write: sector on A18..A11, 01h sets, 00h clears, upper data ignored
// - volatile writes accepted whatever persistent bits or freeze bit hold
// - every volatile bit cleared by reset
// - read/reset command returns the block to normal reading
// - volatile writes accepted with the secure otp overlay enabled too
// - unlock clears freeze only when all 64 entered bits match the password
// - unlock portion within 2 us of previous one is ignored
// - x32: address bit 0 picks half, lower half first
// - x16: two low address bits pick portion, order 00,01,10,11
// - out of order portions report no match, freeze stays set
// - unlock busy: busy pin low, small bank toggles bit 6
// - about 1 us per portion, then busy released
// - persistent program: sector on A18..A11, 60h, select line low
// - freeze set and bit already set: no program, time-out
// - 60h with select line high bulk erases all persistent bits
// - freeze set: no bulk erase, ends by time-out
// - protected if persistent bit set, else if volatile bit set
// - status verify reports volatile, persistent and freeze bits
// - only successful unlock or reset clears the freeze bit
// - on freeze set, persistent bits copied into volatile bits
// - 60h enters nv mode; bit 6 toggles, then value on bit 0
module spbc_core
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic bus_x32,
   input wire logic otp_overlay_en,
   input wire logic [`SPBC_SA_W-1:0] sector_addr,
   input wire logic [1:0] portion_addr,
   input wire logic program_erase_select_line,
   input wire logic [31:0] wr_data,
   input wire logic vlock_wr,
   input wire logic nv_cmd_wr,
   input wire logic reset_cmd_wr,
   input wire logic freeze_set_wr,
   input wire logic unlock_wr,
   input wire logic [63:0] password,
   input wire logic [1:0] verify_sel,
   input wire logic small_bank_rd,
   input wire logic [`SPBC_SA_W-1:0] query_sector,
   input wire logic [31:0] array_rd_data,
   output logic [31:0] rd_data,
   output logic busy_indicator_pin,
   output logic persistent_lock_freeze,
   output logic [`SPBC_NUM_SECTORS-1:0] sector_protected,
   output logic verify_value
);
   localparam int NS = `SPBC_NUM_SECTORS;

   spbc_timer_if tif ();
   spbc_timer u_timer
   (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .tif(tif)
   );

   // ****************************************************
   // state
   // ****************************************************
   spbc_pkg::spbc_state_t state_q;
   spbc_pkg::spbc_state_t state_d;
   spbc_pkg::spbc_nvop_t op_q;
   logic [NS-1:0] vol_q;
   logic [NS-1:0] pers_q;
   logic freeze_q;
   logic [1:0] next_portion_q;
   logic match_q;
   logic [`SPBC_CNT_W-1:0] gap_q;
   logic toggle_q;
   logic bit_value_q;
   logic nv_mode_q;
   logic [`SPBC_SA_W-1:0] op_sector_q;
   logic [31:0] rd_data_q;
   logic verify_q;

   // ****************************************************
   // decode
   // ****************************************************
   wire idle = (state_q == spbc_pkg::SPBC_IDLE);
   wire sect_ok = (sector_addr < NS);
   wire vlock_set = (wr_data[7:0] == `SPBC_CMD_VLOCK_SET);
   wire vlock_clr = (wr_data[7:0] == `SPBC_CMD_VLOCK_CLR);
   // otp overlay state is not consulted freeze/persistent neither
   wire vlock_go = vlock_wr & sect_ok & (vlock_set | vlock_clr);
   wire nv_go = nv_cmd_wr & idle
                & (wr_data[7:0] == `SPBC_CMD_NV_PE);
   wire do_erase = nv_go & program_erase_select_line;
   wire do_prog = nv_go & ~program_erase_select_line & sect_ok;
   wire prog_block = freeze_q & pers_q[sector_addr[5:0]];
   wire erase_block = freeze_q;
   // too-early portions are ignored altogether
   wire unlock_go = unlock_wr & idle & (gap_q == 8'h00);
   wire [1:0] want = bus_x32 ? {1'b0, next_portion_q[0]} : next_portion_q;
   wire [1:0] got = bus_x32 ? {1'b0, portion_addr[0]} : portion_addr;
   wire in_order = (got == want);
   wire [31:0] pw_x32 = portion_addr[0] ? password[63:32] :
                        password[31:0];
   wire [15:0] pw_x16 = password[16*portion_addr +: 16];
   wire part_ok = bus_x32 ? (wr_data == pw_x32) :
                  (wr_data[15:0] == pw_x16);
   wire last_portion = bus_x32 ? (got == 2'h1) : (got == 2'h3);
   wire match_now = match_q & part_ok & in_order;
   wire freeze_rise = freeze_set_wr & ~freeze_q;
   wire in_busy = (state_q == spbc_pkg::SPBC_UNLOCK_BUSY) |
                  (state_q == spbc_pkg::SPBC_NV_BUSY) |
                  (state_q == spbc_pkg::SPBC_NV_TIMEOUT);

   assign tif.start = unlock_go | nv_go;
   assign tif.load = unlock_go ? 8'(`SPBC_BUSY_CYC) :
                     (do_erase & erase_block) | (do_prog & prog_block) ?
                     8'(`SPBC_TMO_CYC) : 8'(`SPBC_NV_CYC);

   // ****************************************************
   // sequencer
   // ****************************************************
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         spbc_pkg::SPBC_IDLE:
         begin
            if (unlock_go)
               state_d = spbc_pkg::SPBC_UNLOCK_BUSY;
            else if ((do_erase & erase_block) | (do_prog & prog_block))
               state_d = spbc_pkg::SPBC_NV_TIMEOUT;
            else if (do_erase | do_prog)
               state_d = spbc_pkg::SPBC_NV_BUSY;
         end
         spbc_pkg::SPBC_UNLOCK_BUSY:
            if (tif.done)
               state_d = spbc_pkg::SPBC_IDLE;
         spbc_pkg::SPBC_NV_BUSY,
         spbc_pkg::SPBC_NV_TIMEOUT:
            if (tif.done)
               state_d = spbc_pkg::SPBC_NV_DONE;
         spbc_pkg::SPBC_NV_DONE:
            if (reset_cmd_wr)
               state_d = spbc_pkg::SPBC_IDLE;
         default:
            state_d = spbc_pkg::SPBC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= spbc_pkg::SPBC_IDLE;
         op_q <= spbc_pkg::SPBC_OP_NONE;
         op_sector_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         if (nv_go)
         begin
            op_q <= do_erase ? spbc_pkg::SPBC_OP_ERASE :
                    spbc_pkg::SPBC_OP_PROGRAM;
            op_sector_q <= sector_addr;
         end
      end
   end

   // ****************************************************
   // protection bits
   // ****************************************************
   genvar s;
   generate
      for (s = 0; s < NS; s++)
      begin : g_sect
         wire pick = (sector_addr == 8'(s));
         wire nv_end = tif.done & (state_q == spbc_pkg::SPBC_NV_BUSY);
         always_ff @(posedge sys_clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               vol_q[s] <= 1'b0;
               pers_q[s] <= 1'b0;
            end
            else
            begin
               if (freeze_rise)
                  vol_q[s] <= pers_q[s];
               else if (vlock_go & pick)
                  vol_q[s] <= vlock_set;
               if (nv_end & (op_q == spbc_pkg::SPBC_OP_ERASE))
                  pers_q[s] <= 1'b0;
               else if (nv_end & (op_sector_q == 8'(s)))
                  pers_q[s] <= 1'b1;
            end
         end
         // persistent bit dominates, else volatile bit
         assign sector_protected[s] = pers_q[s] | vol_q[s];
      end
   endgenerate

   // ****************************************************
   // password unlock
   // ****************************************************
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         freeze_q <= 1'b0;
         next_portion_q <= 2'h0;
         match_q <= 1'b1;
         gap_q <= 8'h00;
      end
      else
      begin
         if (unlock_go)
            gap_q <= 8'(`SPBC_GAP_CYC);
         else if (gap_q != 8'h00)
            gap_q <= gap_q - 8'h01;
         if (freeze_rise)
            freeze_q <= 1'b1;
         else if (unlock_go & last_portion & match_now)
            freeze_q <= 1'b0;
         if (unlock_go)
         begin
            // order tracking restarts after the final portion
            next_portion_q <= last_portion ? 2'h0 : next_portion_q + 2'h1;
            match_q <= last_portion ? 1'b1 : match_now;
         end
         else if (reset_cmd_wr & idle)
         begin
            next_portion_q <= 2'h0;
            match_q <= 1'b1;
         end
      end
   end

   // ****************************************************
   // status and read path
   // ****************************************************
   wire vfy_vol = vol_q[query_sector[5:0]];
   wire vfy_pers = pers_q[query_sector[5:0]];
   wire vfy_sel = (verify_sel == `SPBC_VFY_VOL) ? vfy_vol :
                  (verify_sel == `SPBC_VFY_PERS) ? vfy_pers :
                  (verify_sel == `SPBC_VFY_FRZ) ? freeze_q : 1'b0;
   // done value: program ok if bit set; erase ok if all clear
   wire nv_result = (op_q == spbc_pkg::SPBC_OP_ERASE) ? ~|pers_q :
                    pers_q[op_sector_q[5:0]];
   wire show_status = in_busy & small_bank_rd;
   wire [31:0] status_word = {25'h0, toggle_q, 5'h0, bit_value_q};

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         toggle_q <= 1'b0;
         bit_value_q <= 1'b0;
         nv_mode_q <= 1'b0;
         rd_data_q <= 32'h0;
         verify_q <= 1'b0;
      end
      else
      begin
         if (show_status)
            toggle_q <= ~toggle_q;
         if (state_q == spbc_pkg::SPBC_NV_DONE)
            bit_value_q <= nv_result;
         nv_mode_q <= (state_d == spbc_pkg::SPBC_NV_DONE);
         // large bank always sees array data
         rd_data_q <= show_status ? status_word :
                      (nv_mode_q & small_bank_rd) ?
                      {31'h0, bit_value_q} : array_rd_data;
         verify_q <= vfy_sel;
      end
   end

   assign rd_data = rd_data_q;
   assign busy_indicator_pin = ~in_busy;
   assign persistent_lock_freeze = freeze_q;
   assign verify_value = verify_q;
endmodule

// [tb/spbc_asserts.sv]
`include "spbc_params.svh"

// ***************************
// protection checker
// ***************************
module spbc_asserts
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [`SPBC_SA_W-1:0] sector_addr,
   input wire logic [31:0] wr_data,
   input wire logic vlock_wr,
   input wire logic nv_cmd_wr,
   input wire logic freeze_set_wr,
   input wire logic unlock_wr,
   input wire logic [1:0] verify_sel,
   input wire logic small_bank_rd,
   input wire logic [31:0] array_rd_data,
   input wire logic [31:0] rd_data,
   input wire logic busy_indicator_pin,
   input wire logic persistent_lock_freeze,
   input wire logic [`SPBC_NUM_SECTORS-1:0] sector_protected,
   input wire logic verify_value
);
   logic [7:0] gap_q;
   logic [7:0] low_q;
   logic unl_q;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // saturating counters: cycles since unlock busy began, cycles busy low
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gap_q <= 8'hFF;
         low_q <= 8'h00;
         unl_q <= 1'b0;
      end
      else
      begin
         gap_q <= (!busy_indicator_pin && $past(unlock_wr)) ? 8'h00 :
            gap_q + {7'h00, gap_q != 8'hFF};
         low_q <= busy_indicator_pin ? 8'h00 :
            low_q + {7'h00, low_q != 8'hFF};
         unl_q <= !busy_indicator_pin && (unl_q || $past(unlock_wr));
      end
   end
   sequence s_vset;
      vlock_wr && wr_data[7:0] == `SPBC_CMD_VLOCK_SET && !freeze_set_wr
         && sector_addr < `SPBC_NUM_SECTORS;
   endsequence
   sequence s_early;
      unlock_wr && busy_indicator_pin && !nv_cmd_wr && gap_q < 8'h61;
   endsequence
   a_reset_clear: assert property ($rose(reset_n) |->
      sector_protected == '0 && !persistent_lock_freeze)
      else $error("state not clear after reset");
   a_vlock_set: assert property (s_vset |=>
      sector_protected[$past(sector_addr)])
      else $error("volatile set left sector open");
   a_freeze_set: assert property (freeze_set_wr |=>
      persistent_lock_freeze) else $error("freeze bit not set");
   a_early_drop: assert property (s_early |=> busy_indicator_pin)
      else $error("early unlock portion was taken");
   a_unlock_span: assert property ($rose(busy_indicator_pin) && unl_q
      |-> low_q >= 8'h2D && low_q <= 8'h38)
      else $error("unlock busy length wrong");
   a_busy_bound: assert property (low_q < 8'hE6)
      else $error("busy never released");
   a_freeze_hold: assert property ($fell(persistent_lock_freeze) |->
      $past(unlock_wr) || $past(unlock_wr, 2))
      else $error("freeze cleared without unlock");
   a_verify_frz: assert property (verify_sel == `SPBC_VFY_FRZ |=>
      verify_value == $past(persistent_lock_freeze))
      else $error("freeze verify wrong");
   a_large_bank: assert property (!small_bank_rd |=>
      rd_data == $past(array_rd_data)) else $error("large bank data wrong");
endmodule

bind spbc_core spbc_asserts spbc_asserts_i (.*);

// [tb/spbc_host.sv]
`include "spbc_params.svh"

// ***************************
// host command model
// ***************************
module spbc_host
(
   input wire logic sys_clk,
   input wire logic busy_indicator_pin,
   output logic [7:0] sector_addr,
   output logic [1:0] portion_addr,
   output logic program_erase_select_line,
   output logic [31:0] wr_data,
   output logic [4:0] stb
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sector_addr = 8'h00;
      portion_addr = 2'h0;
      program_erase_select_line = 1'b0;
      wr_data = 32'h0;
      stb = 5'h00;
   end
   // one write cycle; k picks vlock, nv, reset, freeze or unlock
   task automatic put(input int k, input logic [7:0] sa,
      input logic [1:0] pa, input logic [31:0] d);
      @(posedge sys_clk);
      sector_addr <= sa;
      portion_addr <= pa;
      wr_data <= d;
      stb <= 5'h01 << k;
      @(posedge sys_clk);
      stb <= 5'h00;
      wr_data <= ~d; // released bus keeps no stale value
   endtask
   task automatic gap();
      repeat (105) @(posedge sys_clk);
   endtask
   task automatic nv(input logic sel, input logic [7:0] sa);
      int n;
      n = 0;
      program_erase_select_line <= sel;
      put(1, sa, 2'h0, 32'(`SPBC_CMD_NV_PE));
      repeat (3) @(posedge sys_clk);
      while (!busy_indicator_pin && n < 300)
      begin
         @(posedge sys_clk);
         n++;
      end
      put(2, 8'h00, 2'h0, 32'(`SPBC_CMD_RESET));
   endtask
endmodule

// [tb/testbench.sv]
`include "spbc_params.svh"

// ***************************
// protection bench
// ***************************
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset_n, bus_x32, otp_overlay_en, small_bank_rd, look, frz;
   logic [1:0] portion_addr, verify_sel;
   logic [7:0] sector_addr, query_sector, s;
   logic [31:0] wr_data, array_rd_data, rd_data;
   logic [63:0] password;
   logic [4:0] stb;
   logic [`SPBC_NUM_SECTORS-1:0] sector_protected, vol, pers;
   logic program_erase_select_line, busy_indicator_pin;
   logic persistent_lock_freeze, verify_value;
   logic [`SPBC_NUM_SECTORS+1:0] exp_q[$];
   int failures, n_tests;
   wire vlock_wr = stb[0];
   wire nv_cmd_wr = stb[1];
   wire reset_cmd_wr = stb[2];
   wire freeze_set_wr = stb[3];
   wire unlock_wr = stb[4];
   spbc_core spbc_core_i (.*);
   spbc_host spbc_host_i (.*);
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [63:0] a, input logic [63:0] b);
      n_tests++;
      if (a !== b)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, a, b);
      end
   endtask
   task automatic results();
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic note(input logic [1:0] vs, input logic [7:0] qs);
      logic e;
      e = vs == `SPBC_VFY_VOL ? vol[qs] : vs == `SPBC_VFY_PERS ? pers[qs] :
         vs == `SPBC_VFY_FRZ ? frz : 1'b0;
      @(posedge sys_clk);
      verify_sel <= vs;
      query_sector <= qs;
      repeat (2) @(posedge sys_clk);
      exp_q.push_back({frz, e, pers | vol});
      look <= 1'b1;
      @(posedge sys_clk);
      look <= 1'b0;
   endtask
   task automatic unl(input logic [1:0] a, input logic [31:0] d);
      spbc_host_i.put(4, 8'h00, a, d);
      spbc_host_i.gap();
   endtask
   task automatic lock();
      spbc_host_i.put(3, 8'h00, 2'h0, 32'h0);
      frz = 1'b1;
      vol = pers;
   endtask
   always @(negedge sys_clk)
      if (look)
         chk({persistent_lock_freeze, verify_value, sector_protected},
            exp_q.pop_front());
   always @(posedge sys_clk)
   begin
      small_bank_rd <= 1'($urandom);
      array_rd_data <= $urandom;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      results();
   end
   initial
   begin
      void'($urandom(32'hACF2DC0A));
      // bank inputs belong to the random driver alone
      {reset_n, otp_overlay_en, look, frz} = 4'h0;
      {verify_sel, query_sector} = '0;
      bus_x32 = 1'b1;
      password = {$urandom, $urandom};
      vol = '0;
      pers = '0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      note(2'h2, 8'h00);
      s = 8'($urandom % 46);
      spbc_host_i.put(0, s, 2'h0, ($urandom & 32'hFFFFFF00) | 32'h01);
      vol[s] = 1'b1;
      note(2'h0, s);
      spbc_host_i.put(0, s, 2'h0, $urandom & 32'hFFFFFF00);
      vol[s] = 1'b0;
      note(2'h0, s);
      spbc_host_i.nv(1'b0, 8'h07);
      pers[7] = 1'b1;
      note(2'h1, 8'h07);
      lock();
      note(2'h0, 8'h07);
      otp_overlay_en <= 1'b1;
      spbc_host_i.put(0, 8'h09, 2'h0, 32'h01);
      vol[9] = 1'b1;
      note(2'h0, 8'h09);
      spbc_host_i.nv(1'b1, 8'h00);
      note(2'h1, 8'h07);
      unl(2'h1, password[63:32]);
      unl(2'h0, password[31:0]);
      note(2'h2, 8'h00);
      // half-done attempt must restart before a fresh lower half
      spbc_host_i.put(2, 8'h00, 2'h0, 32'(`SPBC_CMD_RESET));
      spbc_host_i.put(4, 8'h00, 2'h0, password[31:0]);
      repeat (60) @(posedge sys_clk);
      spbc_host_i.put(4, 8'h00, 2'h1, ~password[63:32]);
      spbc_host_i.gap();
      unl(2'h1, password[63:32]);
      frz = 1'b0;
      note(2'h2, 8'h00);
      bus_x32 <= 1'b0;
      lock();
      for (int t = 0; t < 2; t++)
      begin
         for (int i = 0; i < 4; i++)
            unl(2'(i), {16'($urandom), password[16*i +: 16] ^
               {15'h0, t == 0 && i == 2}});
         frz = t == 0;
         note(2'h2, 8'h00);
      end
      spbc_host_i.nv(1'b1, 8'h00);
      pers = '0;
      note(2'h1, 8'h07);
      reset_n <= 1'b0;
      @(posedge sys_clk);
      reset_n <= 1'b1;
      vol = '0;
      note(2'h0, 8'h09);
      results();
   end
endmodule
